// file: design/mfs_pkg.sv
// Package for the measurement function selection block
package mfs_pkg;

	// Function bit positions within the enabled mask
	localparam int          MFS_NFUNC     = 3;
	localparam int          MFS_AMPS_BIT  = 0;
	localparam int          MFS_VOLTS_BIT = 1;
	localparam int          MFS_OHMS_BIT  = 2;
	localparam logic [2:0]  MFS_FN_NONE   = 3'h0;
	localparam logic [2:0]  MFS_FN_AMPS   = 3'h1;
	localparam logic [2:0]  MFS_FN_VOLTS  = 3'h2;
	localparam logic [2:0]  MFS_FN_OHMS   = 3'h4;
	localparam logic [2:0]  MFS_FN_ALL    = 3'h7;
	localparam logic [1:0]  MFS_FN_TOTAL  = 2'h3;

	// Register byte offsets
	localparam logic [7:0]  MFS_CFG_OFS   = 8'h00;
	localparam logic [7:0]  MFS_CMD_OFS   = 8'h04;
	localparam logic [7:0]  MFS_STAT_OFS  = 8'h08;
	localparam logic [7:0]  MFS_ERR_OFS   = 8'h0c;
	localparam logic [7:0]  MFS_ISTAT_OFS = 8'h10;
	localparam logic [7:0]  MFS_IMASK_OFS = 8'h14;
	localparam logic [7:0]  MFS_RANGE_OFS = 8'h18;
	localparam logic [7:0]  MFS_WORD_STEP = 8'h04;

	// Command register fields
	localparam int          MFS_OP_LSB    = 0;
	localparam int          MFS_OP_MSB    = 3;
	localparam int          MFS_MASK_LSB  = 8;
	localparam int          MFS_MASK_MSB  = 10;

	// Status register fields
	localparam int          MFS_ST_CONC   = 0;
	localparam int          MFS_ST_EN_LSB = 4;
	localparam int          MFS_ST_ON_LSB = 8;
	localparam int          MFS_ST_OFF_LSB = 12;
	localparam int          MFS_ST_QUERY  = 16;
	localparam int          MFS_ST_BUSY   = 17;

	// Interrupt event bits
	localparam int          MFS_NIRQ      = 3;
	localparam int          MFS_IRQ_DONE  = 0;
	localparam int          MFS_IRQ_ERR   = 1;
	localparam int          MFS_IRQ_CONC  = 2;

	// Error numbers, 16-bit two's complement
	localparam logic [15:0] MFS_ERR_NONE  = 16'h0000;
	localparam logic [15:0] MFS_ERR_CONC  = 16'h033f;
	localparam logic [15:0] MFS_ERR_MULTI = 16'hff94;

	localparam int          MFS_RANGE_W   = 8;
	localparam logic [7:0]  MFS_RANGE_RST = 8'h00;

	typedef enum logic [3:0] {
		MFS_OP_NOP      = 4'h0,
		MFS_OP_CONC_ON  = 4'h1,
		MFS_OP_CONC_OFF = 4'h2,
		MFS_OP_FUNC_ON  = 4'h3,
		MFS_OP_FUNC_OFF = 4'h4,
		MFS_OP_ON_ALL   = 4'h5,
		MFS_OP_OFF_ALL  = 4'h6,
		MFS_OP_STATE    = 4'h7
	} mfs_op_t;

	typedef enum logic [1:0] {
		MFS_IDLE = 2'b01,
		MFS_EXEC = 2'b10
	} mfs_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} mfs_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} mfs_apb_rsp_t;

endpackage : mfs_pkg

// file: design/mfs_popcount.sv
// Enabled and disabled function counts from the enabled mask
`timescale 1ns/10ps
module mfs_popcount
	import mfs_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [2:0]       en_mask,
	output logic      [1:0]       on_count,
	output logic      [1:0]       off_count
);

	always_comb
	begin
		on_count = 2'h0;
		for (int i = 0; i < MFS_NFUNC; i++)
		begin
			on_count = on_count + {1'b0, en_mask[i]};
		end
		off_count = MFS_FN_TOTAL - on_count;
	end

	a_count_total : assert property (@(posedge clk) disable iff (!resetn)
		(on_count + off_count == MFS_FN_TOTAL) && (on_count == $countones(en_mask)))
		else $error("enabled and disabled counts disagree with mask");

endmodule : mfs_popcount

// file: design/mfs_irq.sv
// Sticky interrupt status with mask and one level output
`timescale 1ns/10ps
module mfs_irq
	import mfs_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic [MFS_NIRQ-1:0] event_set,
	input  wire logic [MFS_NIRQ-1:0] clear_w1c,
	input  wire logic [MFS_NIRQ-1:0] mask_reg,
	output logic      [MFS_NIRQ-1:0] status_reg,
	output logic                     irq
);

	genvar g;
	generate
		for (g = 0; g < MFS_NIRQ; g++)
		begin : g_bit
			// Set wins over a clear in the same cycle
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					status_reg[g] <= 1'b0;
				else if (event_set[g])
					status_reg[g] <= 1'b1;
				else if (clear_w1c[g])
					status_reg[g] <= 1'b0;
			end
		end
	endgenerate

	assign irq = |(status_reg & mask_reg);

	a_irq_sticky : assert property (@(posedge clk) disable iff (!resetn)
		|event_set |=> ((status_reg & $past(event_set)) == $past(event_set)))
		else $error("event did not set its status bit");

endmodule : mfs_irq

// file: design/mfs_select.sv
// Measurement function selection: command executor, APB registers, ranges
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module mfs_select
	import mfs_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire mfs_apb_req_t                apb_req,
	output mfs_apb_rsp_t                     apb_rsp,
	input  wire logic                        meas_trigger,
	output logic [MFS_NFUNC-1:0]             measure_req,
	output logic [MFS_NFUNC-1:0]             func_enabled,
	output logic [MFS_NFUNC-1:0][MFS_RANGE_W-1:0] func_range,
	output logic                             irq
);

	mfs_state_t                          st_reg;
	logic                                pulse_reg;
	logic                                conc_reg;
	logic                                conc_next;
	logic [2:0]                          en_reg;
	logic [2:0]                          en_next;
	logic [15:0]                         err_reg;
	logic [15:0]                         err_next;
	logic                                err_set;
	logic                                query_reg;
	logic                                query_next;
	mfs_op_t                             op_reg;
	logic [2:0]                          mask_reg;
	logic [MFS_NIRQ-1:0]                 imask_reg;
	logic [MFS_NIRQ-1:0]                 istat;
	logic [MFS_NIRQ-1:0]                 ievent;
	logic [MFS_NIRQ-1:0]                 iclear;
	logic [MFS_NFUNC-1:0][MFS_RANGE_W-1:0] range_reg;
	logic [MFS_NFUNC-1:0][MFS_RANGE_W-1:0] applied_reg;
	logic [MFS_NFUNC-1:0]                measure_reg;
	logic [1:0]                          on_count;
	logic [1:0]                          off_count;
	logic [31:0]                         prdata_reg;
	logic [31:0]                         rdata;
	logic                                hit;
	logic                                wr_acc;
	logic                                setup;
	logic                                cmd_wr;
	logic                                exec;
	logic                                multi;
	logic [2:0]                          low_bit;
	logic [7:0]                          addr;

	////////////////////////////////////////////////////////////////////////
	// APB decode
	assign addr   = apb_req.paddr;
	assign setup  = apb_req.psel && !apb_req.penable;
	assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && hit;
	assign cmd_wr = wr_acc && (addr == MFS_CMD_OFS) && (st_reg == MFS_IDLE);
	assign exec   = (st_reg == MFS_EXEC);

	always_comb
	begin
		hit   = 1'b1;
		rdata = 32'h0000_0000;
		case (addr)
			MFS_CFG_OFS:   rdata[0] = pulse_reg;
			MFS_CMD_OFS:   rdata = 32'h0000_0000;
			MFS_STAT_OFS:
			begin
				rdata[MFS_ST_CONC]                     = conc_reg;
				rdata[MFS_ST_EN_LSB +: MFS_NFUNC]      = en_reg;
				rdata[MFS_ST_ON_LSB +: 2]              = on_count;
				rdata[MFS_ST_OFF_LSB +: 2]             = off_count;
				rdata[MFS_ST_QUERY]                    = query_reg;
				rdata[MFS_ST_BUSY]                     = exec;
			end
			MFS_ERR_OFS:   rdata[15:0] = err_reg;
			MFS_ISTAT_OFS: rdata[MFS_NIRQ-1:0] = istat;
			MFS_IMASK_OFS: rdata[MFS_NIRQ-1:0] = imask_reg;
			MFS_RANGE_OFS: rdata[MFS_RANGE_W-1:0] = range_reg[MFS_AMPS_BIT];
			MFS_RANGE_OFS + MFS_WORD_STEP: rdata[MFS_RANGE_W-1:0] = range_reg[MFS_VOLTS_BIT];
			MFS_RANGE_OFS + MFS_WORD_STEP + MFS_WORD_STEP:
				rdata[MFS_RANGE_W-1:0] = range_reg[MFS_OHMS_BIT];
			default:       hit = 1'b0;
		endcase
	end

	// Read data captured in the setup cycle, valid during access
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			prdata_reg <= 32'h0000_0000;
		else if (setup)
			prdata_reg <= apb_req.pwrite ? 32'h0000_0000 : rdata;
	end

	assign apb_rsp.prdata  = prdata_reg;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !hit;

	////////////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pulse_reg <= 1'b0;
		else if (wr_acc && addr == MFS_CFG_OFS)
			pulse_reg <= apb_req.pwdata[0];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			imask_reg <= '0;
		else if (wr_acc && addr == MFS_IMASK_OFS)
			imask_reg <= apb_req.pwdata[MFS_NIRQ-1:0];
	end

	genvar g;
	generate
		for (g = 0; g < MFS_NFUNC; g++)
		begin : g_func
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					range_reg[g] <= MFS_RANGE_RST;
				else if (wr_acc && addr == MFS_RANGE_OFS + MFS_WORD_STEP * 8'(g))
					range_reg[g] <= apb_req.pwdata[MFS_RANGE_W-1:0];
			end
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					applied_reg[g] <= MFS_RANGE_RST;
				else if (en_reg[g])
					applied_reg[g] <= range_reg[g];
			end
			a_range_apply : assert property (@(posedge clk) disable iff (!resetn)
				en_reg[g] |=> applied_reg[g] == $past(range_reg[g]))
				else $error("selected function did not take its stored range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Command capture and executor
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_reg   <= MFS_OP_NOP;
			mask_reg <= MFS_FN_NONE;
		end
		else if (cmd_wr)
		begin
			op_reg   <= mfs_op_t'(apb_req.pwdata[MFS_OP_MSB:MFS_OP_LSB]);
			mask_reg <= apb_req.pwdata[MFS_MASK_MSB:MFS_MASK_LSB];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_reg <= MFS_IDLE;
		else
		begin
			case (st_reg)
				MFS_IDLE: st_reg <= cmd_wr ? MFS_EXEC : MFS_IDLE;
				MFS_EXEC: st_reg <= MFS_IDLE;
				default:  st_reg <= MFS_IDLE;
			endcase
		end
	end

	assign multi   = (mask_reg & (mask_reg - 3'h1)) != 3'h0;
	assign low_bit = mask_reg & (~mask_reg + 3'h1);

	always_comb
	begin
		conc_next  = conc_reg;
		en_next    = en_reg;
		err_next   = MFS_ERR_NONE;
		query_next = query_reg;
		if (pulse_reg && conc_reg)
		begin
			conc_next = 1'b0;
			en_next   = MFS_FN_VOLTS;
		end
		else if (exec)
		begin
			case (op_reg)
				MFS_OP_CONC_ON:
				begin
					// set flag, refused in pulse variant
					if (pulse_reg)
						err_next = MFS_ERR_CONC;
					else
						conc_next = 1'b1;
				end
				MFS_OP_CONC_OFF:
				begin
					if (conc_reg)
						en_next = MFS_FN_VOLTS;
					conc_next = 1'b0;
				end
				MFS_OP_FUNC_ON:
				begin
					// add named, lowest named only when not concurrent, refuse several in pulse variant
					if (conc_reg)
						en_next = en_reg | mask_reg;
					else if (multi && pulse_reg)
						err_next = MFS_ERR_MULTI;
					else if (mask_reg != MFS_FN_NONE)
						en_next = low_bit;
				end
				MFS_OP_FUNC_OFF: en_next = en_reg & ~mask_reg;
				MFS_OP_ON_ALL:
				begin
					if (pulse_reg)
						err_next = MFS_ERR_CONC;
					else
						en_next = conc_reg ? MFS_FN_ALL : MFS_FN_OHMS;
				end
				MFS_OP_OFF_ALL:  en_next = MFS_FN_NONE;
				MFS_OP_STATE:    query_next = |(en_reg & mask_reg);
				default:         en_next = en_reg;
			endcase
		end
	end

	assign err_set = (err_next != MFS_ERR_NONE);

	// enabled set as three-bit mask, with flag and query result
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			conc_reg  <= 1'b0;
			en_reg    <= MFS_FN_VOLTS;
			query_reg <= 1'b0;
		end
		else
		begin
			conc_reg  <= conc_next;
			en_reg    <= en_next;
			query_reg <= query_next;
		end
	end

	// New error wins over a software clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			err_reg <= MFS_ERR_NONE;
		else if (err_set)
			err_reg <= err_next;
		else if (wr_acc && addr == MFS_ERR_OFS)
			err_reg <= MFS_ERR_NONE;
	end

	////////////////////////////////////////////////////////////////////////
	// Measurement requests
	// one request per enabled function
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			measure_reg <= MFS_FN_NONE;
		else
			measure_reg <= meas_trigger ? en_reg : MFS_FN_NONE;
	end

	assign measure_req  = measure_reg;
	assign func_enabled = en_reg;
	assign func_range   = applied_reg;

	////////////////////////////////////////////////////////////////////////
	// Counts and interrupts
	// counts from the mask
	mfs_popcount u_count (
		.clk       (clk),
		.resetn    (resetn),
		.en_mask   (en_reg),
		.on_count  (on_count),
		.off_count (off_count)
	);

	always_comb
	begin
		ievent               = '0;
		ievent[MFS_IRQ_DONE] = exec;
		ievent[MFS_IRQ_ERR]  = err_set;
		ievent[MFS_IRQ_CONC] = conc_reg && !conc_next;
		iclear = (wr_acc && addr == MFS_ISTAT_OFS) ? apb_req.pwdata[MFS_NIRQ-1:0] : '0;
	end

	mfs_irq u_irq (
		.clk        (clk),
		.resetn     (resetn),
		.event_set  (ievent),
		.clear_w1c  (iclear),
		.mask_reg   (imask_reg),
		.status_reg (istat),
		.irq        (irq)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_exec(mfs_op_t op);
		exec && op_reg == op && !(pulse_reg && conc_reg);
	endsequence

	a_conc_set : assert property (s_exec(MFS_OP_CONC_ON) ##0 !pulse_reg |=> conc_reg)
		else $error("concurrency flag not set by on command");
	a_conc_drop : assert property ($fell(conc_reg) |-> en_reg == MFS_FN_VOLTS)
		else $error("voltage not sole function after concurrency off");
	a_single_en : assert property (!conc_reg |-> $countones(en_reg) <= 1)
		else $error("more than one function enabled without concurrency");
	a_func_off : assert property (s_exec(MFS_OP_FUNC_OFF) |=> (en_reg & $past(mask_reg)) == 3'h0)
		else $error("disabled function still enabled");
	a_meas_all : assert property (meas_trigger |=> measure_req == $past(en_reg))
		else $error("measurement request does not match enabled set");
	a_all_three : assert property (s_exec(MFS_OP_ON_ALL) ##0 (conc_reg && !pulse_reg)
		|=> en_reg == MFS_FN_ALL)
		else $error("enable-all did not enable three functions");
	a_all_ohms : assert property (s_exec(MFS_OP_ON_ALL) ##0 (!conc_reg && !pulse_reg)
		|=> en_reg == MFS_FN_OHMS)
		else $error("enable-all without concurrency not ohms only");
	a_off_all : assert property (s_exec(MFS_OP_OFF_ALL) |=> en_reg == MFS_FN_NONE)
		else $error("disable-all left a function enabled");
	a_pulse_conc : assert property (pulse_reg ##1 pulse_reg |-> !conc_reg)
		else $error("concurrency set in pulse variant");
	a_pulse_all : assert property (s_exec(MFS_OP_ON_ALL) ##0 pulse_reg
		|=> err_reg == MFS_ERR_CONC && $stable(en_reg))
		else $error("enable-all not refused in pulse variant");
	a_pulse_multi : assert property (s_exec(MFS_OP_FUNC_ON) ##0 (pulse_reg && multi)
		|=> err_reg == MFS_ERR_MULTI && $stable(en_reg))
		else $error("multiple enable not refused in pulse variant");
	a_state_query : assert property (s_exec(MFS_OP_STATE)
		|=> query_reg == |($past(en_reg) & $past(mask_reg)))
		else $error("state query result wrong");
endmodule : mfs_select

// file: verification/mfs_host_model.sv
// Host model that drives commands and register accesses over APB
`timescale 1ns/10ps
module mfs_host_model
	import mfs_pkg::*;
(
	input  wire logic         clk,
	output mfs_apb_req_t      apb_req,
	input  wire mfs_apb_rsp_t apb_rsp
);

	initial apb_req = '0;

	////////////////////////////////////////////////////////////////////////////////
	// One transfer: setup, then access until ready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		@(posedge clk);
		while (apb_rsp.pready !== 1'b1)
			@(posedge clk);
		rdata = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : xfer

	////////////////////////////////////////////////////////////////////////////////
	// function list packed
	task automatic cmd(input mfs_op_t op, input logic [2:0] fmask);
		logic [31:0] rdata;
		logic        err;
		xfer(1'b1, MFS_CMD_OFS, {21'h0, fmask, 4'h0, op}, rdata, err);
		repeat (2) @(posedge clk);
	endtask : cmd

endmodule : mfs_host_model

// file: verification/measure_function_select_tb_top.sv
// Self-checking bench for the measurement function selection block
`timescale 1ns/10ps
module measure_function_select_tb_top
	import mfs_pkg::*;
;

	logic                                  clk;
	logic                                  resetn;
	logic                                  meas_trigger;
	mfs_apb_req_t                          apb_req;
	mfs_apb_rsp_t                          apb_rsp;
	logic [MFS_NFUNC-1:0]                  measure_req;
	logic [MFS_NFUNC-1:0]                  func_enabled;
	logic [MFS_NFUNC-1:0][MFS_RANGE_W-1:0] func_range;
	logic                                  irq;
	int                                    errors;
	int                                    n_tests;
	logic [31:0]                           rd;
	logic                                  er;

	mfs_select DUT (
		.clk          (clk),
		.resetn       (resetn),
		.apb_req      (apb_req),
		.apb_rsp      (apb_rsp),
		.meas_trigger (meas_trigger),
		.measure_req  (measure_req),
		.func_enabled (func_enabled),
		.func_range   (func_range),
		.irq          (irq)
	);

	mfs_host_model host (
		.clk     (clk),
		.apb_req (apb_req),
		.apb_rsp (apb_rsp)
	);

	always #20 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Compare, report and finish
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////////////
	// Register access helpers
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd, er);
	endtask : wr_reg

	task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, rd, er);
		chk(name, exp, rd);
		chk("slave error", 32'h0, {31'h0, er});
	endtask : chk_reg

	function automatic logic [31:0] stat_exp(input logic conc, input logic [2:0] m);
		logic [1:0] on;
		on = 2'(m[0]) + 2'(m[1]) + 2'(m[2]);
		return {18'h0, 2'(3 - on), 2'h0, on, 1'b0, m, 3'h0, conc};
	endfunction : stat_exp

	task automatic chk_stat(input logic conc, input logic [2:0] m);
		host.xfer(1'b0, MFS_STAT_OFS, 32'h0, rd, er);
		chk("status", stat_exp(conc, m), rd & 32'h0000_3fff);
		chk("enabled pins", {29'h0, m}, {29'h0, func_enabled});
	endtask : chk_stat

	task automatic chk_query(input logic [2:0] m, input logic exp);
		host.cmd(MFS_OP_STATE, m);
		host.xfer(1'b0, MFS_STAT_OFS, 32'h0, rd, er);
		chk("state query", {31'h0, exp}, {31'h0, rd[MFS_ST_QUERY]});
	endtask : chk_query

	task automatic trig(input logic [2:0] m);
		@(posedge clk);
		meas_trigger <= 1'b1;
		@(posedge clk);
		meas_trigger <= 1'b0;
		@(negedge clk);
		chk("measure pulse", {29'h0, m}, {29'h0, measure_req});
		@(negedge clk);
		chk("measure idle", 32'h0, {29'h0, measure_req});
	endtask : trig

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		$display("ERROR watchdog expected end seen hang");
		test_done();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		meas_trigger = 1'b0;
		errors = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		chk_stat(1'b0, MFS_FN_VOLTS);
		chk_reg("error", MFS_ERR_OFS, 32'h0);
		chk_reg("irq mask", MFS_IMASK_OFS, 32'h0);
		chk_reg("command", MFS_CMD_OFS, 32'h0);
		for (int i = 0; i < 3; i++)
			chk_reg("range reset", MFS_RANGE_OFS + MFS_WORD_STEP * 8'(i), 32'h0);
		for (int i = 0; i < 3; i++)
			wr_reg(MFS_RANGE_OFS + MFS_WORD_STEP * 8'(i), 32'(8'h11 * (i + 1)));
		for (int i = 0; i < 3; i++)
			chk_reg("range", MFS_RANGE_OFS + MFS_WORD_STEP * 8'(i), 32'(8'h11 * (i + 1)));
		chk("amps range held", 32'h0, {24'h0, func_range[0]});
		chk("volts range", 32'h22, {24'h0, func_range[1]});
		chk("ohms range held", 32'h0, {24'h0, func_range[2]});
		wr_reg(MFS_IMASK_OFS, 32'h1);
		host.cmd(MFS_OP_CONC_ON, 3'h0);
		chk_stat(1'b1, MFS_FN_VOLTS);
		chk("irq raised", 32'h1, {31'h0, irq});
		chk_reg("irq status", MFS_ISTAT_OFS, 32'h1);
		wr_reg(MFS_ISTAT_OFS, 32'h7);
		wr_reg(MFS_IMASK_OFS, 32'h4);
		chk_reg("irq status cleared", MFS_ISTAT_OFS, 32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		host.cmd(MFS_OP_OFF_ALL, 3'h0);
		chk_stat(1'b1, MFS_FN_NONE);
		host.cmd(MFS_OP_ON_ALL, 3'h0);
		chk_stat(1'b1, MFS_FN_ALL);
		chk("irq masked", 32'h0, {31'h0, irq});
		trig(MFS_FN_ALL);
		host.cmd(MFS_OP_FUNC_OFF, MFS_FN_VOLTS);
		chk_stat(1'b1, MFS_FN_AMPS | MFS_FN_OHMS);
		trig(MFS_FN_AMPS | MFS_FN_OHMS);
		chk_query(MFS_FN_VOLTS, 1'b0);
		chk_query(MFS_FN_OHMS, 1'b1);
		host.cmd(MFS_OP_FUNC_ON, MFS_FN_VOLTS);
		chk_stat(1'b1, MFS_FN_ALL);
		host.cmd(MFS_OP_FUNC_OFF, MFS_FN_VOLTS);
		host.cmd(MFS_OP_CONC_OFF, 3'h0);
		chk_stat(1'b0, MFS_FN_VOLTS);
		chk("irq on fall", 32'h1, {31'h0, irq});
		chk_reg("irq status fall", MFS_ISTAT_OFS, 32'h5);
		host.cmd(MFS_OP_FUNC_ON, MFS_FN_AMPS | MFS_FN_OHMS);
		chk_stat(1'b0, MFS_FN_AMPS);
		host.cmd(MFS_OP_FUNC_ON, MFS_FN_OHMS);
		chk_stat(1'b0, MFS_FN_OHMS);
		host.cmd(MFS_OP_FUNC_OFF, MFS_FN_OHMS);
		host.cmd(MFS_OP_ON_ALL, 3'h0);
		chk_stat(1'b0, MFS_FN_OHMS);
		chk("ohms range applied", 32'h33, {24'h0, func_range[2]});
		host.cmd(MFS_OP_OFF_ALL, 3'h0);
		chk_stat(1'b0, MFS_FN_NONE);
		chk_reg("error none", MFS_ERR_OFS, 32'h0);
		host.cmd(MFS_OP_CONC_ON, 3'h0);
		wr_reg(MFS_CFG_OFS, 32'h1);
		chk_stat(1'b0, MFS_FN_VOLTS);
		host.cmd(MFS_OP_OFF_ALL, 3'h0);
		host.cmd(MFS_OP_CONC_ON, 3'h0);
		chk_stat(1'b0, MFS_FN_NONE);
		chk_reg("error conc", MFS_ERR_OFS, {16'h0, MFS_ERR_CONC});
		chk_reg("irq status error", MFS_ISTAT_OFS, 32'h7);
		wr_reg(MFS_ERR_OFS, 32'h0);
		host.cmd(MFS_OP_FUNC_ON, MFS_FN_AMPS | MFS_FN_VOLTS);
		chk_stat(1'b0, MFS_FN_NONE);
		chk_reg("error multi", MFS_ERR_OFS, {16'h0, MFS_ERR_MULTI});
		wr_reg(MFS_ERR_OFS, 32'h0);
		host.cmd(MFS_OP_ON_ALL, 3'h0);
		chk_stat(1'b0, MFS_FN_NONE);
		chk_reg("error all", MFS_ERR_OFS, {16'h0, MFS_ERR_CONC});
		host.xfer(1'b0, 8'h40, 32'h0, rd, er);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		test_done();
	end

endmodule : measure_function_select_tb_top
